// file: shared/ccd_pkg.sv
// Constants for the clock ratio and module clock gate block.
package ccd_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFF_RATIO = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_GATE_A = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_GATE_B = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h0c;
  localparam int RATIO_W = 15;
  localparam int GATE_W = 8;
  localparam int NUM_CLK = 5;
  localparam int NUM_MOD = 10;
  // Ratio field least significant bit positions.
  localparam int POS_CORE = 12;
  localparam int POS_BUS = 9;
  localparam int POS_PERIPH = 6;
  localparam int POS_TIMER_S = 3;
  localparam int POS_TIMER = 0;
  // Derived clock indices.
  localparam int CLK_CORE = 0;
  localparam int CLK_BUS = 1;
  localparam int CLK_PERIPH = 2;
  localparam int CLK_TIMER_S = 3;
  localparam int CLK_TIMER = 4;
  // Stop bit positions in the two gate registers.
  localparam int POS_RAM_STOP = 7;
  localparam int POS_ROM_STOP = 6;
  localparam int POS_XFER_STOP = 4;
  localparam int POS_DMA_STOP = 3;
  localparam int POS_TIMER_S_STOP = 7;
  localparam int POS_TIMER_STOP = 6;
  localparam int POS_CMP_STOP = 5;
  localparam int POS_CONV2_STOP = 2;
  localparam int POS_CONV1_STOP = 1;
  localparam int POS_CONV0_STOP = 0;
  localparam logic [GATE_W-1:0] GATE_A_MASK = 8'hd8;
  localparam logic [GATE_W-1:0] GATE_B_MASK = 8'he7;
  // Module enable indices and the derived clock each module runs from.
  localparam int MOD_RAM = 0;
  localparam int MOD_ROM = 1;
  localparam int MOD_XFER = 2;
  localparam int MOD_DMA = 3;
  localparam int MOD_TIMER_S = 4;
  localparam int MOD_TIMER = 5;
  localparam int MOD_CMP = 6;
  localparam int MOD_CONV2 = 7;
  localparam int MOD_CONV1 = 8;
  localparam int MOD_CONV0 = 9;
  localparam int MOD_SRC [NUM_MOD] = '{CLK_CORE, CLK_CORE, CLK_BUS, CLK_BUS, CLK_TIMER_S,
                                        CLK_TIMER, CLK_PERIPH, CLK_PERIPH, CLK_PERIPH, CLK_PERIPH};
  // Reset values.
  localparam logic [RATIO_W-1:0] RATIO_RST = 15'h0000;
  localparam logic [GATE_W-1:0] GATE_A_RST = 8'h00;
  localparam logic [GATE_W-1:0] GATE_B_RST = 8'h00;
  // Ratio codes.
  localparam logic [2:0] RATIO_FULL = 3'h0;
  localparam logic [2:0] RATIO_HALF = 3'h1;
  localparam logic [2:0] RATIO_THIRD = 3'h2;
  localparam logic [2:0] RATIO_QUARTER = 3'h3;
  localparam logic [2:0] RATIO_SIXTH = 3'h4;
  // Common phase counter covers every divisor, so all ticks share edges.
  localparam int PHASE_W = 5;
  localparam logic [PHASE_W-1:0] PHASE_LAST = 5'h17;
  localparam int POS_STAT_PHASE = 16;
endpackage : ccd_pkg

// file: shared/ccd_gate_if.sv
// Connection between the ratio core and one module clock gate.
`timescale 1ns/10ps
interface ccd_gate_if;
  logic src_tick;
  logic stop_req;
  logic boundary;
  logic gated;
  logic stop_act;
  modport ctrl (output src_tick, output stop_req, output boundary, input gated, input stop_act);
  modport gate (input src_tick, input stop_req, input boundary, output gated, output stop_act);
endinterface : ccd_gate_if

// file: design/ccd_gate.sv
// Glitch-free gate for one module clock enable.
`timescale 1ns/10ps
module ccd_gate
  import ccd_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  ccd_gate_if.gate gif
);
  logic stop_r;
  logic gated_r;

  // A stop request only takes effect on the common phase boundary, so a
  // gated enable never loses or gains part of a period.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      stop_r <= 1'b0;
    end else if (gif.boundary) begin
      stop_r <= gif.stop_req;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      gated_r <= 1'b0;
    end else begin
      gated_r <= gif.src_tick & ~stop_r;
    end
  end

  assign gif.gated = gated_r;
  assign gif.stop_act = stop_r;

  a_stop_blocks: assert property (@(posedge ref_clk_in) disable iff (rst_in) stop_r |=> !gated_r)
    else $error("gated enable ran while module stopped");
  a_run_passes: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (!rst_in && !stop_r && gif.src_tick) |=> gated_r)
    else $error("gated enable missing while module running");
  a_stop_glitchfree: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    !gif.boundary |=> $stable(stop_r))
    else $error("stop state changed off the boundary");
endmodule : ccd_gate

// file: design/ccd_top.sv
// Clock ratio control and module clock gating with its register port.
// Function
// - Five 3-bit ratio fields sit in the ratio register: core 14..12, bus 11..9, periph 8..6, timer_s 5..3, timer 2..0.
// - Ratio code 000 makes the selected derived clock run at the full rate of the multiplied source.
// - Ratio code 001 makes the selected derived clock run at half the full rate.
// - A module stop bit at 1 halts that module's clock and at 0 keeps it clocked.
// - Gate register A bit 7 stops the RAM clock and bit 6 stops the ROM clock.
// - Gate register A bit 4 stops the transfer controller clock and bit 3 stops the DMA controller clock.
// - Gate register B bits 7, 6 and 5 stop the second motor timer, first motor timer and compare-match timer.
// - Gate register B bits 2, 1 and 0 stop converter units 2, 1 and 0.
//
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/10ps
module ccd_top
  import ccd_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  output logic [DATA_W-1:0] rd_data_out,
  output logic core_clk_en_out,
  output logic bus_clk_en_out,
  output logic periph_clk_en_out,
  output logic timer_s_clk_en_out,
  output logic timer_clk_en_out,
  output logic [NUM_MOD-1:0] module_clk_en_out
);
  // ref_clk_in is taken as the already multiplied source; derived clocks are
  // one-cycle enables so that every consumer stays on this single clock.

  function automatic logic ccd_tick(input logic [PHASE_W-1:0] ph, input logic [2:0] code);
    logic t;
    t = 1'b0;
    case (code)
      RATIO_FULL: t = 1'b1;
      RATIO_HALF: t = (ph[0] == 1'b0);
      RATIO_THIRD: t = ((ph % 5'h03) == 5'h00);
      RATIO_QUARTER: t = (ph[1:0] == 2'h0);
      RATIO_SIXTH: t = ((ph % 5'h06) == 5'h00);
      default: t = (ph[2:0] == 3'h0);
    endcase
    return t;
  endfunction : ccd_tick

  function automatic logic [2:0] ccd_field(input logic [RATIO_W-1:0] r, input int pos);
    return r[pos +: 3];
  endfunction : ccd_field

  logic [RATIO_W-1:0] clock_ratio_control_r;
  logic [GATE_W-1:0] module_clock_gate_a_r;
  logic [GATE_W-1:0] module_clock_gate_b_r;
  logic [RATIO_W-1:0] ratio_act_r;
  logic [PHASE_W-1:0] phase_r;
  logic [NUM_CLK-1:0] clk_en_r;
  logic [NUM_CLK-1:0] tick_nxt;
  logic [NUM_MOD-1:0] stop_req;
  logic [NUM_MOD-1:0] stop_act;
  logic [DATA_W-1:0] rd_data_r;
  logic [DATA_W-1:0] rd_data_nxt;
  logic wrap;

  assign wrap = (phase_r == PHASE_LAST);

  // Register writes.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      clock_ratio_control_r <= RATIO_RST;
    end else if (wr_en_in && addr_in == OFF_RATIO) begin
      clock_ratio_control_r <= wr_data_in[RATIO_W-1:0];
    end
  end

  // Reserved gate bits are held at zero.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      module_clock_gate_a_r <= GATE_A_RST;
    end else if (wr_en_in && addr_in == OFF_GATE_A) begin
      module_clock_gate_a_r <= wr_data_in[GATE_W-1:0] & GATE_A_MASK;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      module_clock_gate_b_r <= GATE_B_RST;
    end else if (wr_en_in && addr_in == OFF_GATE_B) begin
      module_clock_gate_b_r <= wr_data_in[GATE_W-1:0] & GATE_B_MASK;
    end
  end

  // Single free-running phase counter shared by all derived clocks.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      phase_r <= '0;
    end else if (wrap) begin
      phase_r <= '0;
    end else begin
      phase_r <= phase_r + 5'h01;
    end
  end

  // New ratios apply at the wrap, where every divisor has a common edge,
  // so a change never produces a short period.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      ratio_act_r <= RATIO_RST;
    end else if (wrap) begin
      ratio_act_r <= clock_ratio_control_r;
    end
  end

  always_comb begin
    tick_nxt = '0;
    tick_nxt[CLK_CORE] = ccd_tick(phase_r, ccd_field(ratio_act_r, POS_CORE));
    tick_nxt[CLK_BUS] = ccd_tick(phase_r, ccd_field(ratio_act_r, POS_BUS));
    tick_nxt[CLK_PERIPH] = ccd_tick(phase_r, ccd_field(ratio_act_r, POS_PERIPH));
    tick_nxt[CLK_TIMER_S] = ccd_tick(phase_r, ccd_field(ratio_act_r, POS_TIMER_S));
    tick_nxt[CLK_TIMER] = ccd_tick(phase_r, ccd_field(ratio_act_r, POS_TIMER));
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      clk_en_r <= '0;
    end else begin
      clk_en_r <= tick_nxt;
    end
  end

  assign core_clk_en_out = clk_en_r[CLK_CORE];
  assign bus_clk_en_out = clk_en_r[CLK_BUS];
  assign periph_clk_en_out = clk_en_r[CLK_PERIPH];
  assign timer_s_clk_en_out = clk_en_r[CLK_TIMER_S];
  assign timer_clk_en_out = clk_en_r[CLK_TIMER];

  // Map stop bits onto the module gates.
  always_comb begin
    stop_req = '0;
    stop_req[MOD_RAM] = module_clock_gate_a_r[POS_RAM_STOP];
    stop_req[MOD_ROM] = module_clock_gate_a_r[POS_ROM_STOP];
    stop_req[MOD_XFER] = module_clock_gate_a_r[POS_XFER_STOP];
    stop_req[MOD_DMA] = module_clock_gate_a_r[POS_DMA_STOP];
    stop_req[MOD_TIMER_S] = module_clock_gate_b_r[POS_TIMER_S_STOP];
    stop_req[MOD_TIMER] = module_clock_gate_b_r[POS_TIMER_STOP];
    stop_req[MOD_CMP] = module_clock_gate_b_r[POS_CMP_STOP];
    stop_req[MOD_CONV2] = module_clock_gate_b_r[POS_CONV2_STOP];
    stop_req[MOD_CONV1] = module_clock_gate_b_r[POS_CONV1_STOP];
    stop_req[MOD_CONV0] = module_clock_gate_b_r[POS_CONV0_STOP];
  end

  ccd_gate_if gif [NUM_MOD] ();

  for (genvar g = 0; g < NUM_MOD; g++) begin : g_gate
    assign gif[g].src_tick = tick_nxt[MOD_SRC[g]];
    assign gif[g].stop_req = stop_req[g];
    assign gif[g].boundary = wrap;
    assign module_clk_en_out[g] = gif[g].gated;
    assign stop_act[g] = gif[g].stop_act;
    ccd_gate u_gate (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .gif(gif[g])
    );
  end

  // Read data stands for exactly the cycle after the strobe.
  always_comb begin
    rd_data_nxt = '0;
    if (rd_en_in) begin
      case (addr_in)
        OFF_RATIO: rd_data_nxt[RATIO_W-1:0] = clock_ratio_control_r;
        OFF_GATE_A: rd_data_nxt[GATE_W-1:0] = module_clock_gate_a_r;
        OFF_GATE_B: rd_data_nxt[GATE_W-1:0] = module_clock_gate_b_r;
        OFF_STATUS: begin
          rd_data_nxt[NUM_MOD-1:0] = stop_act;
          rd_data_nxt[POS_STAT_PHASE +: PHASE_W] = phase_r;
        end
        default: rd_data_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      rd_data_r <= '0;
    end else begin
      rd_data_r <= rd_data_nxt;
    end
  end

  assign rd_data_out = rd_data_r;

  sequence s_bus_half_steady;
    ccd_field(ratio_act_r, POS_BUS) == RATIO_HALF && !wrap;
  endsequence

  // The sampled reset term keeps the release edge, where the enables are still cleared, out of the antecedent.
  a_core_full: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    !rst_in && ccd_field(ratio_act_r, POS_CORE) == RATIO_FULL |=> core_clk_en_out)
    else $error("full-rate core enable missed a cycle");
  a_bus_half: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    s_bus_half_steady ##1 s_bus_half_steady |=> bus_clk_en_out != $past(bus_clk_en_out))
    else $error("half-rate bus enable did not alternate");
  a_ratio_write: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (wr_en_in && addr_in == OFF_RATIO) |=> clock_ratio_control_r == $past(wr_data_in[RATIO_W-1:0]))
    else $error("ratio register not written");
  a_ratio_aligned: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    !wrap |=> $stable(ratio_act_r))
    else $error("active ratio changed off the wrap");
  a_phase_wrap: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    wrap |=> phase_r == 5'h00 ##1 phase_r == 5'h01)
    else $error("phase counter did not wrap to zero");
  a_ram_stop: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (wrap && module_clock_gate_a_r[POS_RAM_STOP]) |=> ##1 !module_clk_en_out[MOD_RAM])
    else $error("RAM enable not stopped");
  a_dma_stop: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (wrap && module_clock_gate_a_r[POS_DMA_STOP]) |=> ##1 !module_clk_en_out[MOD_DMA])
    else $error("DMA controller enable not stopped");
  a_cmp_stop: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (wrap && module_clock_gate_b_r[POS_CMP_STOP]) |=> ##1 !module_clk_en_out[MOD_CMP])
    else $error("compare-match timer enable not stopped");
  a_conv0_run: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (wrap && !module_clock_gate_b_r[POS_CONV0_STOP]) |=> ##1
    module_clk_en_out[MOD_CONV0] == periph_clk_en_out)
    else $error("converter 0 enable does not follow the peripheral clock");
endmodule : ccd_top

// file: dv/clock_divider_module_stop_test.sv
// Self-checking bench for the clock ratio and module clock gate block.
`timescale 1ns/10ps
module clock_divider_module_stop_test;
  import ccd_pkg::*;
  typedef struct packed {logic [15:0] ratio; logic [7:0] ga; logic [7:0] gb;} ccd_row_t;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [ADDR_W-1:0] addr_in = '0;
  logic [DATA_W-1:0] wr_data_in = '0;
  logic wr_en_in = 1'b0;
  logic rd_en_in = 1'b0;
  logic [DATA_W-1:0] rd_data_out;
  logic [4:0] clk_en;
  logic [NUM_MOD-1:0] mod_en;
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [31:0] stat_exp;
  // Each row sets all three registers; the first is the usual application setup.
  ccd_row_t rows [6] = '{'{16'h0241, 8'h28, 8'hfe}, '{16'h0000, 8'h00, 8'h00}, '{16'h1234, 8'h90, 8'h01},
                         '{16'h7fff, 8'hff, 8'hff}, '{16'h4c5a, 8'h48, 8'ha4}, '{16'ha0d1, 8'h00, 8'h42}};

  ccd_top dut (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .addr_in(addr_in),
    .wr_data_in(wr_data_in),
    .wr_en_in(wr_en_in),
    .rd_en_in(rd_en_in),
    .rd_data_out(rd_data_out),
    .core_clk_en_out(clk_en[CLK_CORE]),
    .bus_clk_en_out(clk_en[CLK_BUS]),
    .periph_clk_en_out(clk_en[CLK_PERIPH]),
    .timer_s_clk_en_out(clk_en[CLK_TIMER_S]),
    .timer_clk_en_out(clk_en[CLK_TIMER]),
    .module_clk_en_out(mod_en)
  );

  always #12.5 ref_clk_in = ~ref_clk_in;

  // Cycles since reset; modulo the wrap length this is the shared phase.
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      cyc <= 0;
    end else begin
      cyc <= cyc + 1;
    end
  end

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic report_and_stop;
    if (bad_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    addr_in <= a;
    wr_data_in <= d;
    wr_en_in <= 1'b1;
    @(posedge ref_clk_in);
    wr_en_in <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input string name, input logic [31:0] exp);
    @(posedge ref_clk_in);
    addr_in <= a;
    rd_en_in <= 1'b1;
    @(posedge ref_clk_in);
    rd_en_in <= 1'b0;
    @(negedge ref_clk_in);
    check(name, exp, rd_data_out);
  endtask : rd

  function automatic int period(input logic [2:0] c);
    case (c)
      3'h0: return 1;
      3'h1: return 2;
      3'h2: return 3;
      3'h3: return 4;
      3'h4: return 6;
      default: return 8;
    endcase
  endfunction : period

  // Any 24 consecutive cycles hold exactly 24/divisor pulses, so the phase alignment does not matter.
  task automatic count_check(input ccd_row_t r);
    int cnt [5];
    int mc [NUM_MOD];
    int exp [5];
    int pos [5];
    int spos [NUM_MOD];
    logic stop;
    pos = '{POS_CORE, POS_BUS, POS_PERIPH, POS_TIMER_S, POS_TIMER};
    spos = '{POS_RAM_STOP, POS_ROM_STOP, POS_XFER_STOP, POS_DMA_STOP, POS_TIMER_S_STOP, POS_TIMER_STOP,
             POS_CMP_STOP, POS_CONV2_STOP, POS_CONV1_STOP, POS_CONV0_STOP};
    cnt = '{default: 0};
    mc = '{default: 0};
    // Settings are applied only at the 24-cycle wrap, so let two wraps pass first.
    repeat (50) @(posedge ref_clk_in);
    repeat (24) begin
      @(negedge ref_clk_in);
      for (int i = 0; i < 5; i++) cnt[i] += (clk_en[i] === 1'b1);
      for (int m = 0; m < NUM_MOD; m++) mc[m] += (mod_en[m] === 1'b1);
    end
    for (int i = 0; i < 5; i++) begin
      exp[i] = 24 / period(r.ratio[pos[i] +: 3]);
      check("clock enable count", 32'(exp[i]), 32'(cnt[i]));
    end
    for (int m = 0; m < NUM_MOD; m++) begin
      stop = (m < 4) ? r.ga[spos[m]] : r.gb[spos[m]];
      check("module enable count", stop ? 32'h0 : 32'(exp[MOD_SRC[m]]), 32'(mc[m]));
    end
  endtask : count_check

  task automatic reset_and_check;
    @(posedge ref_clk_in);
    rst_in <= 1'b1;
    repeat (4) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    rd(OFF_RATIO, "ratio after reset", 32'h0);
    rd(OFF_GATE_A, "gate a after reset", 32'h0);
    rd(OFF_GATE_B, "gate b after reset", 32'h0);
    count_check('0);
  endtask : reset_and_check

  initial begin
    repeat (4000) @(posedge ref_clk_in);
    bad_count++;
    report_and_stop();
  end

  initial begin
    reset_and_check();
    foreach (rows[k]) begin
      wr(OFF_RATIO, 32'(rows[k].ratio));
      wr(OFF_GATE_A, 32'(rows[k].ga));
      wr(OFF_GATE_B, 32'(rows[k].gb));
      rd(OFF_RATIO, "ratio readback", 32'(rows[k].ratio & 16'h7fff));
      rd(OFF_GATE_A, "gate a readback", 32'(rows[k].ga & GATE_A_MASK));
      rd(OFF_GATE_B, "gate b readback", 32'(rows[k].gb & GATE_B_MASK));
      count_check(rows[k]);
    end
    // The last row stops the first motor timer and converter 1; the phase is the one at the read edge.
    @(posedge ref_clk_in);
    addr_in <= OFF_STATUS;
    rd_en_in <= 1'b1;
    @(posedge ref_clk_in);
    stat_exp = 32'((1 << MOD_TIMER) | (1 << MOD_CONV1)) | (32'(cyc % (int'(PHASE_LAST) + 1)) << POS_STAT_PHASE);
    rd_en_in <= 1'b0;
    @(negedge ref_clk_in);
    check("status", stat_exp, rd_data_out);
    // Write then three reads with no gap; read data stand for one cycle only.
    @(posedge ref_clk_in);
    addr_in <= OFF_RATIO;
    wr_data_in <= 32'h0000_8241;
    wr_en_in <= 1'b1;
    @(posedge ref_clk_in);
    wr_en_in <= 1'b0;
    rd_en_in <= 1'b1;
    @(posedge ref_clk_in);
    addr_in <= 8'h10;
    @(negedge ref_clk_in);
    check("back to back read", 32'h0000_0241, rd_data_out);
    @(posedge ref_clk_in);
    addr_in <= OFF_GATE_B;
    @(negedge ref_clk_in);
    check("unmapped read", 32'h0, rd_data_out);
    @(posedge ref_clk_in);
    rd_en_in <= 1'b0;
    @(negedge ref_clk_in);
    check("gate b back to back", 32'h0000_0042, rd_data_out);
    @(negedge ref_clk_in);
    check("idle read data", 32'h0, rd_data_out);
    wr(8'h10, 32'hffff_ffff);
    rd(OFF_GATE_B, "gate b after unmapped write", 32'h0000_0042);
    // A stop set just before a second reset must be cleared by it.
    wr(OFF_GATE_A, 32'h0000_00d8);
    reset_and_check();
    report_and_stop();
  end
endmodule : clock_divider_module_stop_test
